// ==== include/fsc_pkg.sv ====
// Constants and types shared by the flash status and protection logic
package fsc_pkg;
  // Command codes seen after a frame ends
  localparam logic [7:0] CMD_WREN      = 8'h06;
  localparam logic [7:0] CMD_WRSR1     = 8'h01;
  localparam logic [7:0] CMD_WRSR2     = 8'h31;
  localparam logic [7:0] CMD_WRSR3     = 8'h11;
  localparam logic [7:0] CMD_SUSPEND   = 8'h75;
  localparam logic [7:0] CMD_RESUME    = 8'h7A;
  localparam logic [7:0] CMD_ENTER4B   = 8'hB7;
  localparam logic [7:0] CMD_EXIT4B    = 8'hE9;
  localparam logic [7:0] CMD_PROG      = 8'h02;
  localparam logic [7:0] CMD_QPROG     = 8'h32;
  localparam logic [7:0] CMD_SERASE    = 8'h20;
  localparam logic [7:0] CMD_BERASE32  = 8'h52;
  localparam logic [7:0] CMD_BERASE64  = 8'hD8;
  localparam logic [7:0] CMD_CERASE    = 8'hC7;
  localparam logic [7:0] CMD_SECPROG   = 8'h42;
  localparam logic [7:0] CMD_SECERASE  = 8'h44;
  localparam logic [7:0] CMD_BLKLOCK   = 8'h36;
  localparam logic [7:0] CMD_BLKUNLOCK = 8'h39;
  // Array geometry
  localparam int ADDR_W = 26;
  localparam int BLK_W  = 10;
  localparam int SEC_W  = 4;
  localparam int AREA_LSB = 12;
  localparam logic [10:0] BLK_CNT  = 11'h400;
  localparam logic [3:0]  SIZE_NONE = 4'h0;
  localparam logic [3:0]  SIZE_ALL  = 4'hB;
  // Field positions within each 8-bit status register
  localparam int BP_LSB  = 2;
  localparam int TB_BIT  = 6;
  localparam int QE_BIT  = 1;
  localparam int LB_LSB  = 2;
  localparam int CMP_BIT = 6;
  localparam int SUS_BIT = 7;
  localparam int ADS_BIT = 0;
  localparam int ADP_BIT = 1;
  localparam int WPS_BIT = 2;
  localparam int DRV_LSB = 5;
  // Reset values
  localparam logic [3:0] BP_RST  = 4'h0;
  localparam logic [3:0] LB_RST  = 4'h0;
  localparam logic [1:0] DRV_RST = 2'h0;
  // Drive strength in percent
  localparam logic [6:0] DRV_PCT_100 = 7'h64;
  localparam logic [6:0] DRV_PCT_75  = 7'h4B;
  localparam logic [6:0] DRV_PCT_50  = 7'h32;
  localparam logic [6:0] DRV_PCT_25  = 7'h19;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EVAL = 2'b10
  } fsc_state_t;
endpackage

// ==== src/fsc_status_protect.sv ====
// Status/configuration bits and array write-protection decode
`timescale 1ns/1ps
// Summary of operation
// - Suspend command 75h sets the read-only suspend flag.
// - Resume command 7Ah or a power cycle clears the suspend flag.
// - Four security-area lock bits reset to 0, each settable by status write.
// - A set lock bit stays set; its security area becomes read-only.
// - Quad enable low: pause pin active, only standard and dual transfers.
// - Quad enable high: IO2/IO3 on, pause off, quad transfers allowed.
// - Read-only bit shows current address width, 0 three, 1 four bytes.
// - Power-up width bit read only at init, written only by 06h then 11h.
// - Power-up width bit picks three- or four-byte mode at start.
// - Scheme select 0 uses size-code decode; 1 uses per-block locks.
// - Every per-block/sector lock bit is 1 after power-on or device reset.
// - Drive field 00/01/10/11 gives 100/75/50/25 percent strength.
// - Reserved bits read as zero; writes to them do nothing.
// - Size code 0 none, 1-10 gives 2^(code-1) blocks, 11-15 all.
// - Erase or program touching a protected range is ignored.
// - Complement bit inverts the protected range.
// - Lock mode ignores erase/program on a locked block or edge sector.
module fsc_status_protect #(
  parameter int ADDR_W = fsc_pkg::ADDR_W
) (
  // Clock and power-on reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Serial front end, all asynchronous to clk_sys
  input  wire logic              sclk,
  input  wire logic              csN,
  input  wire logic [7:0]        cmdCode,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [7:0]        cmdData,
  input  wire logic              cmdQuad,
  input  wire logic              devReset,
  // Array operation verdict
  output logic                   opGo,
  output logic                   opReject,
  // Status read-back
  output logic [7:0]             firstStatus,
  output logic [7:0]             secondStatusConfig,
  output logic [7:0]             thirdStatusConfig,
  // Pin and pad control
  output logic                   io23Enable,
  output logic                   pauseEnable,
  output logic                   addr4Byte,
  output logic [6:0]             drivePct
);
  localparam int SW = 18 + ADDR_W + 2;
  localparam logic [SW-1:0] PIN_RST = {{(SW-1){1'b0}}, 1'b1};
  localparam int BW = fsc_pkg::BLK_W;
  localparam int CW = fsc_pkg::SEC_W;

  if (ADDR_W != fsc_pkg::ADDR_W)
  begin : gBadAddr
    $error("Only a 26-bit array address is supported");
  end

  logic [SW-1:0]       pinMeta_r;
  logic [SW-1:0]       pinSync_r;
  logic [7:0]          sCode;
  logic [ADDR_W-1:0]   sAddr;
  logic [7:0]          sData;
  logic                sQuad;
  logic                sDevRst;
  logic                sSclk;
  logic                sCsN;
  logic                csPrev_r;
  logic                sclkPrev_r;
  logic                devRstPrev_r;
  logic                clkSeen_r;
  logic                frameEnd;
  logic                devRstPulse;
  fsc_pkg::fsc_state_t state_r;
  logic [7:0]          code_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [7:0]          data_r;
  logic                quad_r;
  logic                initPend_r;
  // Status fields
  logic                suspendFlag_r;
  logic [3:0]          securityAreaLocks_r;
  logic                quadIoSelect_r;
  logic                currentAddrWidth_r;
  logic                powerupAddrWidth_r;
  logic                protectSchemeSelect_r;
  logic [1:0]          outputDriveLevel_r;
  logic                complementRegion_r;
  logic                bottomSelect_r;
  logic [3:0]          regionSizeCode_r;
  logic                wel_r;
  logic [1023:0]       blkLock_r;
  logic [31:0]         secLock_r;
  // Decode
  logic                eval;
  logic                isArray;
  logic                isSec;
  logic                isCe;
  logic                quadBad;
  logic [BW-1:0]       blk;
  logic [CW-1:0]       sec;
  logic                edgeBlk;
  logic [10:0]         spanCnt;
  logic [10:0]         rLo;
  logic [10:0]         rHi;
  logic [10:0]         opLo;
  logic [10:0]         opHi;
  logic                spanNone;
  logic                protHit;
  logic                lockHit;
  logic                secHit;
  logic                refuse;
  logic                doCmd;
  logic                accepted;
  logic                rejected;

  // Two-stage synchroniser for every pin
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pinMeta_r <= PIN_RST;
      pinSync_r <= PIN_RST;
    end
    else
    begin
      pinMeta_r <= {cmdCode, cmdAddr, cmdData, cmdQuad, devReset, sclk, csN};
      pinSync_r <= pinMeta_r;
    end
  end
  assign {sCode, sAddr, sData, sQuad, sDevRst, sSclk, sCsN} = pinSync_r;

  // Frame boundary; a frame with no clock edge carries no command
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      csPrev_r     <= 1'b1;
      sclkPrev_r   <= 1'b0;
      devRstPrev_r <= 1'b0;
      clkSeen_r    <= 1'b0;
    end
    else
    begin
      csPrev_r     <= sCsN;
      sclkPrev_r   <= sSclk;
      devRstPrev_r <= sDevRst;
      if (sCsN)
        clkSeen_r <= 1'b0;
      else if (sSclk && !sclkPrev_r)
        clkSeen_r <= 1'b1;
    end
  end
  assign frameEnd    = sCsN && !csPrev_r && clkSeen_r;
  assign devRstPulse = sDevRst && !devRstPrev_r;

  // Command capture, one evaluation cycle per frame
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= fsc_pkg::ST_IDLE;
      code_r  <= 8'h00;
      addr_r  <= '0;
      data_r  <= 8'h00;
      quad_r  <= 1'b0;
    end
    else
    begin
      case (state_r)
        fsc_pkg::ST_IDLE:
          if (frameEnd)
          begin
            code_r  <= sCode;
            addr_r  <= sAddr;
            data_r  <= sData;
            quad_r  <= sQuad;
            state_r <= fsc_pkg::ST_EVAL;
          end
        fsc_pkg::ST_EVAL: state_r <= fsc_pkg::ST_IDLE;
        default:          state_r <= fsc_pkg::ST_IDLE;
      endcase
    end
  end

  assign eval    = (state_r == fsc_pkg::ST_EVAL);
  assign isCe    = (code_r == fsc_pkg::CMD_CERASE);
  assign isArray = isCe || code_r == fsc_pkg::CMD_PROG ||
                   code_r == fsc_pkg::CMD_QPROG ||
                   code_r == fsc_pkg::CMD_SERASE ||
                   code_r == fsc_pkg::CMD_BERASE32 ||
                   code_r == fsc_pkg::CMD_BERASE64;
  assign isSec   = code_r == fsc_pkg::CMD_SECPROG ||
                   code_r == fsc_pkg::CMD_SECERASE;
  assign quadBad = quad_r && !quadIoSelect_r;
  assign blk     = addr_r[ADDR_W-1 -: BW];
  assign sec     = addr_r[ADDR_W-BW-1 -: CW];
  assign edgeBlk = (blk == '0) || (blk == '1);

  // Size-code range; complement turns "overlaps" into "not inside"
  always_comb
  begin
    spanNone = (regionSizeCode_r == fsc_pkg::SIZE_NONE);
    spanCnt  = 11'h001 << (regionSizeCode_r - 4'h1);
    if (regionSizeCode_r >= fsc_pkg::SIZE_ALL)
      spanCnt = fsc_pkg::BLK_CNT;
    if (bottomSelect_r)
    begin
      rLo = 11'h000;
      rHi = spanCnt - 11'h001;
    end
    else
    begin
      rLo = fsc_pkg::BLK_CNT - spanCnt;
      rHi = fsc_pkg::BLK_CNT - 11'h001;
    end
    opLo = isCe ? 11'h000 : {1'b0, blk};
    opHi = isCe ? fsc_pkg::BLK_CNT - 11'h001 : {1'b0, blk};
    if (complementRegion_r)
      protHit = spanNone || opLo < rLo || opHi > rHi;
    else
      protHit = !spanNone && opHi >= rLo && opLo <= rHi;
  end

  // Per-block locks; the edge blocks are locked per 4KB sector
  always_comb
  begin
    if (isCe)
      lockHit = (|blkLock_r[1022:1]) || (|secLock_r);
    else if (edgeBlk && code_r == fsc_pkg::CMD_BERASE64)
      lockHit = |secLock_r[blk[0]*16 +: 16];
    else if (edgeBlk)
      lockHit = secLock_r[{blk[0], sec}];
    else
      lockHit = blkLock_r[blk];
  end

  assign secHit   = securityAreaLocks_r[addr_r[fsc_pkg::AREA_LSB +: 2]];
  // Verdict uses fields as they stand in the evaluation cycle
  assign refuse   = !wel_r || (isSec && secHit) || (isArray &&
                    (protectSchemeSelect_r ? lockHit : protHit));
  assign doCmd    = eval && !quadBad;
  assign accepted = doCmd && (isArray || isSec) && !refuse;
  assign rejected = eval && (quadBad || ((isArray || isSec) && refuse));

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      opGo     <= 1'b0;
      opReject <= 1'b0;
    end
    else
    begin
      opGo     <= accepted;
      opReject <= rejected;
    end
  end

  // Write enable latch, dropped by array, security-area and status-write commands; block lock/unlock leave it set
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wel_r <= 1'b0;
    else if (doCmd && code_r == fsc_pkg::CMD_WREN)
      wel_r <= 1'b1;
    else if (doCmd && (isArray || isSec || code_r == fsc_pkg::CMD_WRSR1 ||
             code_r == fsc_pkg::CMD_WRSR2 || code_r == fsc_pkg::CMD_WRSR3))
      wel_r <= 1'b0;
  end

  // Suspend flag; power cycle is modelled by rst
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      suspendFlag_r <= 1'b0;
    else if (doCmd && code_r == fsc_pkg::CMD_SUSPEND)
      suspendFlag_r <= 1'b1;
    else if (doCmd && code_r == fsc_pkg::CMD_RESUME)
      suspendFlag_r <= 1'b0;
  end

  // Writable status fields; reserved and read-only bits are not stored
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      regionSizeCode_r      <= fsc_pkg::BP_RST;
      bottomSelect_r        <= 1'b0;
      complementRegion_r    <= 1'b0;
      quadIoSelect_r        <= 1'b0;
      securityAreaLocks_r   <= fsc_pkg::LB_RST;
      powerupAddrWidth_r    <= 1'b0;
      protectSchemeSelect_r <= 1'b0;
      outputDriveLevel_r    <= fsc_pkg::DRV_RST;
    end
    else if (doCmd && wel_r)
    begin
      if (code_r == fsc_pkg::CMD_WRSR1)
      begin
        regionSizeCode_r <= data_r[fsc_pkg::BP_LSB +: 4];
        bottomSelect_r   <= data_r[fsc_pkg::TB_BIT];
      end
      if (code_r == fsc_pkg::CMD_WRSR2)
      begin
        complementRegion_r  <= data_r[fsc_pkg::CMP_BIT];
        quadIoSelect_r      <= data_r[fsc_pkg::QE_BIT];
        // One-time bits only ever gain ones
        securityAreaLocks_r <= securityAreaLocks_r |
                               data_r[fsc_pkg::LB_LSB +: 4];
      end
      if (code_r == fsc_pkg::CMD_WRSR3)
      begin
        powerupAddrWidth_r    <= data_r[fsc_pkg::ADP_BIT];
        protectSchemeSelect_r <= data_r[fsc_pkg::WPS_BIT];
        outputDriveLevel_r    <= data_r[fsc_pkg::DRV_LSB +: 2];
      end
    end
  end

  // Address width loads from the power-up bit after reset release
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      initPend_r         <= 1'b1;
      currentAddrWidth_r <= 1'b0;
    end
    else
    begin
      initPend_r <= devRstPulse;
      if (initPend_r)
        currentAddrWidth_r <= powerupAddrWidth_r;
      else if (doCmd && code_r == fsc_pkg::CMD_ENTER4B)
        currentAddrWidth_r <= 1'b1;
      else if (doCmd && code_r == fsc_pkg::CMD_EXIT4B)
        currentAddrWidth_r <= 1'b0;
    end
  end

  // Individual locks; unused edge entries of blkLock_r stay set
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      blkLock_r <= '1;
      secLock_r <= '1;
    end
    else if (devRstPulse)
    begin
      blkLock_r <= '1;
      secLock_r <= '1;
    end
    else if (doCmd && (code_r == fsc_pkg::CMD_BLKLOCK ||
             code_r == fsc_pkg::CMD_BLKUNLOCK))
    begin
      if (edgeBlk)
        secLock_r[{blk[0], sec}] <= (code_r == fsc_pkg::CMD_BLKLOCK);
      else
        blkLock_r[blk] <= (code_r == fsc_pkg::CMD_BLKLOCK);
    end
  end

  // Drive strength lookup, registered for the pad
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      drivePct <= fsc_pkg::DRV_PCT_100;
    else
      case (outputDriveLevel_r)
        2'h0:    drivePct <= fsc_pkg::DRV_PCT_100;
        2'h1:    drivePct <= fsc_pkg::DRV_PCT_75;
        2'h2:    drivePct <= fsc_pkg::DRV_PCT_50;
        default: drivePct <= fsc_pkg::DRV_PCT_25;
      endcase
  end

  // Read-back never depends on busy or suspend state
  always_comb
  begin
    firstStatus        = 8'h00;
    secondStatusConfig = 8'h00;
    thirdStatusConfig  = 8'h00;
    firstStatus[fsc_pkg::BP_LSB +: 4] = regionSizeCode_r;
    firstStatus[fsc_pkg::TB_BIT]      = bottomSelect_r;
    secondStatusConfig[fsc_pkg::SUS_BIT]    = suspendFlag_r;
    secondStatusConfig[fsc_pkg::CMP_BIT]    = complementRegion_r;
    secondStatusConfig[fsc_pkg::LB_LSB +: 4] = securityAreaLocks_r;
    secondStatusConfig[fsc_pkg::QE_BIT]     = quadIoSelect_r;
    thirdStatusConfig[fsc_pkg::ADS_BIT]     = currentAddrWidth_r;
    thirdStatusConfig[fsc_pkg::ADP_BIT]     = powerupAddrWidth_r;
    thirdStatusConfig[fsc_pkg::WPS_BIT]     = protectSchemeSelect_r;
    thirdStatusConfig[fsc_pkg::DRV_LSB +: 2] = outputDriveLevel_r;
  end

  assign io23Enable  = quadIoSelect_r;
  assign pauseEnable = !quadIoSelect_r;
  assign addr4Byte   = currentAddrWidth_r;

  susSet_a: assert property (@(posedge clk_sys) disable iff (rst)
    doCmd && code_r == fsc_pkg::CMD_SUSPEND
    |=> secondStatusConfig[fsc_pkg::SUS_BIT])
    else $error("suspend flag not set");
  susClr_a: assert property (@(posedge clk_sys) disable iff (rst)
    doCmd && code_r == fsc_pkg::CMD_RESUME |=> !suspendFlag_r ##1
    !suspendFlag_r || $past(frameEnd, 2) || state_r == fsc_pkg::ST_EVAL)
    else $error("suspend flag not cleared");
  lockSticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (securityAreaLocks_r & $past(securityAreaLocks_r)) ==
    $past(securityAreaLocks_r))
    else $error("security lock bit fell");
  quadRefuse_a: assert property (@(posedge clk_sys) disable iff (rst)
    eval && quad_r && !quadIoSelect_r |=> opReject && !opGo)
    else $error("quad command taken with quad off");
  adsInit_a: assert property (@(posedge clk_sys) disable iff (rst)
    initPend_r |=> currentAddrWidth_r == $past(powerupAddrWidth_r))
    else $error("address width not loaded at init");
  driveMap_a: assert property (@(posedge clk_sys) disable iff (rst)
    outputDriveLevel_r == 2'h2 && $stable(outputDriveLevel_r)
    |=> drivePct == fsc_pkg::DRV_PCT_50)
    else $error("drive strength mismatch");
  topBlock_a: assert property (@(posedge clk_sys) disable iff (rst)
    eval && isArray && !isCe && !protectSchemeSelect_r && !quadBad &&
    !complementRegion_r && !bottomSelect_r && regionSizeCode_r == 4'h1 &&
    blk == 10'h3FF |=> opReject)
    else $error("top block not protected");
  cmpAll_a: assert property (@(posedge clk_sys) disable iff (rst)
    eval && isArray && !protectSchemeSelect_r && complementRegion_r &&
    regionSizeCode_r == fsc_pkg::SIZE_NONE |=> !opGo ##1 !opGo)
    else $error("complement of none left array open");
  noProtGo_a: assert property (@(posedge clk_sys) disable iff (rst)
    opGo |-> $past(!protHit || protectSchemeSelect_r || isSec))
    else $error("protected range accepted");
  lockRst_a: assert property (@(posedge clk_sys) disable iff (rst)
    devRstPulse |=> (&secLock_r) && (&blkLock_r))
    else $error("locks not set by device reset");
  goCov: cover property (@(posedge clk_sys) disable iff (rst) opGo);
  rejCov: cover property (@(posedge clk_sys) disable iff (rst)
    opReject && $past(protHit));
  susCov: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(suspendFlag_r));
endmodule

// ==== testbench/fsc_host_model.sv ====
// Host-side model that frames flash commands on the serial pins
`timescale 1ns/1ps
module fsc_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Serial pins and decoded command fields
  output logic             sclk,
  output logic             csN,
  output logic [7:0]       cmdCode,
  output logic [25:0]      cmdAddr,
  output logic [7:0]       cmdData,
  output logic             cmdQuad,
  // Verdict pulses
  input  wire logic        opGo,
  input  wire logic        opReject
);
  int nGo;
  int nRej;

  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    {cmdCode, cmdAddr, cmdData, cmdQuad} = '0;
  end

  // One command per frame; the caller issues write enable first
  task automatic send(bit [7:0] c, bit [25:0] a, bit [7:0] d, bit q);
    nGo = 0;
    nRej = 0;
    @(negedge clk_sys);
    {cmdCode, cmdAddr, cmdData, cmdQuad} = {c, a, d, q};
    csN = 1'b0;
    // Link clock toggles only inside a frame and idles low
    repeat (2)
    begin
      repeat (4) @(negedge clk_sys);
      sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    csN = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_sys);
      // Fields are no longer valid once the hold time is over
      if (i == 4)
        {cmdCode, cmdAddr, cmdData, cmdQuad} = ~{c, a, d, q};
      // An unknown verdict counts as a pulse, so it cannot pass as silence
      if (opGo !== 1'b0)
        nGo++;
      if (opReject !== 1'b0)
        nRej++;
    end
  endtask
endmodule

// ==== testbench/test_flash_status_config_protect.sv ====
// Self-checking bench for the flash status and protection block
`timescale 1ns/1ps
module test_flash_status_config_protect;
  logic        clk_sys, rst, sclk, csN, cmdQuad, devReset;
  logic        opGo, opReject, io23Enable, pauseEnable, addr4Byte;
  logic [7:0]  cmdCode, cmdData;
  logic [7:0]  firstStatus, secondStatusConfig, thirdStatusConfig;
  logic [25:0] cmdAddr;
  logic [6:0]  drivePct;
  int          fails;
  int          testsRun;
  bit [31:0]   seed = 32'h9050;
  // Reference model of the register fields
  bit [3:0]    bp, lb;
  bit [1:0]    drv;
  bit          tb, cmp, qe, suspend_flag, current_addr_width, powerup_addr_width, protect_scheme_select, wel;
  bit [1023:0] lk;
  bit [15:0]   sk [2];
  logic [6:0]  pct [4] = '{7'h64, 7'h4B, 7'h32, 7'h19};
  // Random command mix, write enable weighted up
  bit [7:0]    mix [32] = '{8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h06,
    8'h06, 8'h06, 8'h01, 8'h01, 8'h01, 8'h31, 8'h11, 8'h75, 8'h7A, 8'hB7,
    8'hE9, 8'h02, 8'h02, 8'h32, 8'h20, 8'h20, 8'h20, 8'h52, 8'hD8, 8'hD8,
    8'hC7, 8'h42, 8'h44, 8'h36, 8'h39, 8'h39};

  fsc_status_protect uut (.clk_sys, .rst, .sclk, .csN, .cmdCode, .cmdAddr,
    .cmdData, .cmdQuad, .devReset, .opGo, .opReject, .firstStatus,
    .secondStatusConfig, .thirdStatusConfig, .io23Enable, .pauseEnable,
    .addr4Byte, .drivePct);
  fsc_host_model host (.clk_sys, .sclk, .csN, .cmdCode, .cmdAddr,
    .cmdData, .cmdQuad, .opGo, .opReject);

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic bit isProt(bit [9:0] blk, bit [3:0] sec, bit [7:0] c);
    int n;
    if (c == fsc_pkg::CMD_CERASE && protect_scheme_select)
      return |lk[1022:1] || |sk[0] || |sk[1];
    if (c == fsc_pkg::CMD_CERASE)
      return cmp ? bp < 11 : bp != 0;
    if (protect_scheme_select && (blk == 10'h000 || blk == 10'h3FF))
      return (c == fsc_pkg::CMD_BERASE64) ? |sk[blk[9]] : sk[blk[9]][sec];
    if (protect_scheme_select)
      return lk[blk];
    n = (bp == 0) ? 0 : (bp > 10) ? 1024 : 1 << (bp - 1);
    return cmp ^ (tb ? blk < n : blk >= 1024 - n);
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    testsRun++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic checkStatus();
    chk("firstStatus", {1'b0, tb, bp, 2'b00}, firstStatus);
    chk("second", {suspend_flag, cmp, lb, qe, 1'b0}, secondStatusConfig);
    chk("third", {1'b0, drv, 2'b00, protect_scheme_select, powerup_addr_width, current_addr_width}, thirdStatusConfig);
    chk("io23Enable", qe, io23Enable);
    chk("pauseEnable", !qe, pauseEnable);
    chk("addr4Byte", current_addr_width, addr4Byte);
    chk("drivePct", pct[drv], drivePct);
  endtask

  task automatic cmd(bit [7:0] c, bit [25:0] a, bit [7:0] d = 8'h00,
                     bit q = 1'b0);
    bit op;
    bit ok;
    bit qOff;
    op = c inside {8'h02, 8'h32, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h42, 8'h44};
    ok = wel && !isProt(a[25:16], a[15:12], c);
    if (c == fsc_pkg::CMD_SECPROG || c == fsc_pkg::CMD_SECERASE)
      ok = wel && !lb[a[13:12]];
    qOff = q && !qe;
    host.send(c, a, d, q);
    chk("opGo", op && ok && !qOff, host.nGo);
    chk("opReject", qOff || (op && !ok), host.nRej);
    if (!qOff)
    begin
      case (c)
        fsc_pkg::CMD_WREN: wel = 1'b1;
        fsc_pkg::CMD_WRSR1: if (wel) {tb, bp} = d[6:2];
        fsc_pkg::CMD_WRSR2: if (wel) {cmp, lb, qe} = {d[6], lb | d[5:2], d[1]};
        fsc_pkg::CMD_WRSR3: if (wel) {drv, protect_scheme_select, powerup_addr_width} = {d[6:5], d[2:1]};
        fsc_pkg::CMD_SUSPEND: suspend_flag = 1'b1;
        fsc_pkg::CMD_RESUME: suspend_flag = 1'b0;
        fsc_pkg::CMD_ENTER4B: current_addr_width = 1'b1;
        fsc_pkg::CMD_EXIT4B: current_addr_width = 1'b0;
        fsc_pkg::CMD_BLKLOCK, fsc_pkg::CMD_BLKUNLOCK:
          if (a[25:16] == 10'h000 || a[25:16] == 10'h3FF)
            sk[a[25]][a[15:12]] = (c == fsc_pkg::CMD_BLKLOCK);
          else
            lk[a[25:16]] = (c == fsc_pkg::CMD_BLKLOCK);
        default: ;
      endcase
      if (op || c inside {8'h01, 8'h31, 8'h11})
        wel = 1'b0;
    end
    checkStatus();
  endtask

  task automatic lockAll();
    lk = '1;
    sk[0] = '1;
    sk[1] = '1;
  endtask

  task automatic powerCycle(int n);
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (n) @(negedge clk_sys);
    rst = 1'b0;
    {bp, lb, drv, tb, cmp, qe, suspend_flag, current_addr_width, powerup_addr_width, protect_scheme_select, wel} = '0;
    lockAll();
    repeat (4) @(negedge clk_sys);
    checkStatus();
  endtask

  task automatic devRst();
    @(negedge clk_sys);
    devReset = 1'b1;
    repeat (4) @(negedge clk_sys);
    devReset = 1'b0;
    repeat (4) @(negedge clk_sys);
    lockAll();
    current_addr_width = powerup_addr_width;
    checkStatus();
    cmd(fsc_pkg::CMD_WREN, 0);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #9000000;
    fails++;
    summarize();
  end

  initial
  begin
    bit [31:0] r;
    bit [31:0] r2;
    bit [9:0]  blk;
    rst = 1'b1;
    devReset = 1'b0;
    powerCycle(12);
    cmd(fsc_pkg::CMD_SUSPEND, 0);
    cmd(fsc_pkg::CMD_RESUME, 0);
    cmd(fsc_pkg::CMD_SUSPEND, 0);
    powerCycle(2);
    cmd(fsc_pkg::CMD_QPROG, 26'h0010000, 8'h00, 1'b1);
    cmd(fsc_pkg::CMD_WRSR2, 0, 8'h06);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_WRSR2, 0, 8'h06);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_WRSR2, 0, 8'h02);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_SECPROG, 26'h0000000);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_SECERASE, 26'h0001000);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_QPROG, 26'h0010000, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      cmd(fsc_pkg::CMD_WREN, 0);
      cmd(fsc_pkg::CMD_WRSR3, 0, 8'(i << 5));
    end
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_WRSR3, 0, 8'hFF);
    devRst();
    cmd(fsc_pkg::CMD_BERASE64, 26'h0050000);
    cmd(fsc_pkg::CMD_BLKUNLOCK, 26'h0050000);
    cmd(fsc_pkg::CMD_BERASE64, 26'h0050000);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_SERASE, 26'h3FF3000);
    cmd(fsc_pkg::CMD_BLKUNLOCK, 26'h3FF3000);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_SERASE, 26'h3FF3000);
    powerCycle(3);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_WRSR1, 0, 8'h04);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_SERASE, 26'h3FF0000);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_WRSR2, 0, 8'h40);
    cmd(fsc_pkg::CMD_WREN, 0);
    cmd(fsc_pkg::CMD_SERASE, 26'h3FE0000);
    for (int i = 0; i < 600; i++)
    begin
      r = xs();
      r2 = xs();
      blk = r[5] ? r[15:6] : (r[6] ? {6'h00, r[10:7]} : 10'h3FF - r[10:7]);
      if (r2[10:5] == 6'h00)
        devRst();
      else
        cmd(mix[r2[4:0]], {blk, r[19:16], r[31:20]}, r2[23:16],
            mix[r2[4:0]] == fsc_pkg::CMD_QPROG);
    end
    summarize();
  end
endmodule
